// [core/acl_core.sv]
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module acl_core (
    // System clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    // Register port
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [15:0] o_reg_rdata,
    // ADC samples in
    input wire logic i_adc_valid,
    input wire acl_pkg::acl_pair_type i_adc,
    // DAC samples out
    output logic o_dac_valid,
    output acl_pkg::acl_pair_type o_dac,
    // Serial audio link
    input wire logic i_bclk,
    input wire logic i_lrclk,
    input wire logic i_rx_sdata,
    output logic o_tx_sdata
);
    import acl_pkg::*;

    typedef enum logic [1:0] {L_IDLE, L_WAIT, L_SHIFT} acl_link_type;

    // System domain state
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic [31:0] tx_hold_r, tx_hold_nxt;
    logic tx_tgl_r, tx_tgl_nxt;
    logic rx_s1_r, rx_s2_r, rx_s3_r;
    logic rx_s1_nxt, rx_s2_nxt, rx_s3_nxt;
    acl_pair_type dac_r, dac_nxt;
    logic dac_vld_r, dac_vld_nxt;
    // Link domain state
    logic [5:0] cfg_s1_r, cfg_s1_nxt;
    logic [5:0] cfg_s2_r, cfg_s2_nxt;
    logic tx_s1_r, tx_s2_r, tx_s3_r;
    logic tx_s1_nxt, tx_s2_nxt, tx_s3_nxt;
    logic [31:0] tx_buf_r, tx_buf_nxt;
    logic lr_q_r, lr_q_nxt;
    acl_link_type state_r, state_nxt;
    logic [4:0] idx_r, idx_nxt;
    logic [31:0] rx_sh_r, rx_sh_nxt;
    logic [31:0] rx_hold_r, rx_hold_nxt;
    logic rx_tgl_r, rx_tgl_nxt;
    logic [31:0] tx_sh_r, tx_sh_nxt;
    logic tx_out_r, tx_out_nxt;
    // Combinational helpers
    logic short_mode, hit, rx_evt;
    logic en_l, pol_l, short_l;
    logic [4:0] last_idx;
    logic lr_rise, go, first, tx_evt;
    logic [31:0] adc_w, dac_w;
    logic [1:0][7:0] tx_code, tx_byte;
    logic [1:0][15:0] rx_lin;

    assign adc_w = i_adc;
    // 8-bit words when companding or a law bit is set
    assign short_mode = ctrl_r[ACL_TX_EN_BIT] | ctrl_r[ACL_RX_EN_BIT] |
                        ctrl_r[ACL_TX_LAW_BIT] | ctrl_r[ACL_RX_LAW_BIT];
    assign hit = (i_reg_addr == ACL_CTRL_ADDR);
    assign rx_evt = rx_s2_r ^ rx_s3_r;

    // Per-channel compress and expand, channel 1 is left
    for (genvar c = 0; c < 2; c++) begin : g_ch
        acl_compress u_cmp (
            .i_sample(adc_w[16 * c +: 16]),
            .i_alaw(ctrl_r[ACL_TX_LAW_BIT]),
            .o_code(tx_code[c])
        );
        acl_expand u_exp (
            .i_code(rx_hold_r[8 * c +: 8]),
            .i_alaw(ctrl_r[ACL_RX_LAW_BIT]),
            .o_sample(rx_lin[c])
        );
        // Companded or plain upper byte
        assign tx_byte[c] = ctrl_r[ACL_TX_EN_BIT] ? tx_code[c] :
                            adc_w[16 * c + 8 +: 8];
        // Expanded, padded byte, or full word
        assign dac_w[16 * c +: 16] = !short_mode ? rx_hold_r[16 * c +: 16] :
            (ctrl_r[ACL_RX_EN_BIT] ? rx_lin[c] :
             {rx_hold_r[8 * c +: 8], 8'h00});
    end

    // System next state: registers, sample capture, DAC feed
    always_comb begin
        ctrl_nxt = ctrl_r;
        rdata_nxt = rdata_r;
        tx_hold_nxt = tx_hold_r;
        tx_tgl_nxt = tx_tgl_r;
        rx_s1_nxt = rx_s1_r;
        rx_s2_nxt = rx_s2_r;
        rx_s3_nxt = rx_s3_r;
        dac_nxt = dac_r;
        dac_vld_nxt = dac_vld_r;
        if (i_clk_en) begin
            if (i_reg_wr && hit) begin
                ctrl_nxt = i_reg_wdata & ACL_CTRL_WMASK;
            end
            rdata_nxt = 16'h0000;
            if (i_reg_rd && hit) begin
                rdata_nxt = ctrl_r;
                rdata_nxt[ACL_SHORT_BIT] = short_mode;
            end
            rx_s1_nxt = rx_tgl_r;
            rx_s2_nxt = rx_s1_r;
            rx_s3_nxt = rx_s2_r;
            dac_vld_nxt = 1'b0;
            if (i_adc_valid) begin
                // Bytes sit in the top slot bits
                tx_hold_nxt = short_mode ?
                              {tx_byte[1], tx_byte[0], 16'h0000} : adc_w;
                tx_tgl_nxt = ~tx_tgl_r;
                if (ctrl_r[ACL_LOOP_BIT]) begin
                    dac_nxt = i_adc;
                    dac_vld_nxt = 1'b1;
                end
            end
            if (rx_evt && !ctrl_r[ACL_LOOP_BIT]) begin
                dac_nxt = dac_w;
                dac_vld_nxt = 1'b1;
            end
        end
    end

    // System registers
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_r <= ACL_CTRL_RESET;
            rdata_r <= 16'h0000;
            tx_hold_r <= 32'h0000_0000;
            tx_tgl_r <= 1'b0;
            rx_s1_r <= 1'b0;
            rx_s2_r <= 1'b0;
            rx_s3_r <= 1'b0;
            dac_r <= '0;
            dac_vld_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            tx_hold_r <= tx_hold_nxt;
            tx_tgl_r <= tx_tgl_nxt;
            rx_s1_r <= rx_s1_nxt;
            rx_s2_r <= rx_s2_nxt;
            rx_s3_r <= rx_s3_nxt;
            dac_r <= dac_nxt;
            dac_vld_r <= dac_vld_nxt;
        end
    end

    assign o_reg_rdata = rdata_r;
    assign o_dac = dac_r;
    assign o_dac_valid = dac_vld_r;

    // Link side views of synchronised settings
    assign en_l = cfg_s2_r[0];
    assign pol_l = cfg_s2_r[1];
    assign short_l = |cfg_s2_r[5:2];
    assign last_idx = short_l ? ACL_LAST_SHORT : ACL_LAST_LONG;
    assign lr_rise = i_lrclk & ~lr_q_r;
    assign tx_evt = tx_s2_r ^ tx_s3_r;

    // Link next state: frame sync and serial shifting
    always_comb begin
        cfg_s1_nxt = {ctrl_r[7:4], ctrl_r[ACL_POL_BIT], i_clk_en};
        cfg_s2_nxt = cfg_s1_r;
        tx_s1_nxt = tx_s1_r;
        tx_s2_nxt = tx_s2_r;
        tx_s3_nxt = tx_s3_r;
        tx_buf_nxt = tx_buf_r;
        lr_q_nxt = lr_q_r;
        state_nxt = state_r;
        idx_nxt = idx_r;
        rx_sh_nxt = rx_sh_r;
        rx_hold_nxt = rx_hold_r;
        rx_tgl_nxt = rx_tgl_r;
        tx_sh_nxt = tx_sh_r;
        tx_out_nxt = tx_out_r;
        go = 1'b0;
        first = 1'b0;
        if (en_l) begin
            tx_s1_nxt = tx_tgl_r;
            tx_s2_nxt = tx_s1_r;
            tx_s3_nxt = tx_s2_r;
            lr_q_nxt = i_lrclk;
            if (tx_evt) begin
                tx_buf_nxt = tx_hold_r;
            end
            // Mode B starts now, mode A one edge later
            if (lr_rise) begin
                if (pol_l) begin
                    go = 1'b1;
                    first = 1'b1;
                end else begin
                    state_nxt = L_WAIT;
                end
            end else begin
                case (state_r)
                    L_WAIT: begin
                        go = 1'b1;
                        first = 1'b1;
                    end
                    L_SHIFT: begin
                        go = 1'b1;
                    end
                    default: ;
                endcase
            end
            if (go) begin
                // Left then right, MSB first, no gap
                idx_nxt = first ? 5'h00 : (idx_r + 5'h01);
                rx_sh_nxt = first ? {31'h0000_0000, i_rx_sdata} :
                            {rx_sh_r[30:0], i_rx_sdata};
                tx_sh_nxt = first ? tx_buf_r : {tx_sh_r[30:0], 1'b0};
                tx_out_nxt = tx_sh_nxt[31];
                state_nxt = L_SHIFT;
                if (idx_nxt == last_idx) begin
                    // Frame done, next may follow at once
                    rx_hold_nxt = rx_sh_nxt;
                    rx_tgl_nxt = ~rx_tgl_r;
                    state_nxt = L_IDLE;
                end
            end else begin
                tx_out_nxt = 1'b0;
            end
        end
    end

    // Link registers
    always_ff @(posedge i_bclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_s1_r <= 6'h00;
            cfg_s2_r <= 6'h00;
            tx_s1_r <= 1'b0;
            tx_s2_r <= 1'b0;
            tx_s3_r <= 1'b0;
            tx_buf_r <= 32'h0000_0000;
            lr_q_r <= 1'b0;
            state_r <= L_IDLE;
            idx_r <= 5'h00;
            rx_sh_r <= 32'h0000_0000;
            rx_hold_r <= 32'h0000_0000;
            rx_tgl_r <= 1'b0;
            tx_sh_r <= 32'h0000_0000;
            tx_out_r <= 1'b0;
        end else begin
            cfg_s1_r <= cfg_s1_nxt;
            cfg_s2_r <= cfg_s2_nxt;
            tx_s1_r <= tx_s1_nxt;
            tx_s2_r <= tx_s2_nxt;
            tx_s3_r <= tx_s3_nxt;
            tx_buf_r <= tx_buf_nxt;
            lr_q_r <= lr_q_nxt;
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_hold_r <= rx_hold_nxt;
            rx_tgl_r <= rx_tgl_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_out_r <= tx_out_nxt;
        end
    end

    assign o_tx_sdata = tx_out_r;

    // Checks on the system side
    loop_path_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_clk_en && i_adc_valid && ctrl_r[ACL_LOOP_BIT])
        |=> (o_dac_valid && o_dac == $past(i_adc)))
        else $error("loopback sample not passed to DAC");
    no_loop_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_clk_en && !ctrl_r[ACL_LOOP_BIT] && !rx_evt) |=> !o_dac_valid)
        else $error("DAC sample without received word");
    comp_short_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_clk_en && i_reg_wr && hit &&
         (i_reg_wdata[ACL_TX_EN_BIT] || i_reg_wdata[ACL_RX_EN_BIT]))
        |=> short_mode)
        else $error("companding did not select 8-bit words");
    plain_byte_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_clk_en && i_adc_valid && short_mode && !ctrl_r[ACL_TX_EN_BIT])
        |=> (tx_hold_r[31:24] == $past(adc_w[31:24]) &&
             tx_hold_r[15:0] == 16'h0000))
        else $error("plain 8-bit word misplaced");
    read_back_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_clk_en && i_reg_rd && hit) |=>
        (o_reg_rdata[7:0] == $past(ctrl_r[7:0])))
        else $error("control read back wrong");
    unmapped_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_clk_en && !(i_reg_rd && hit)) |=> (o_reg_rdata == 16'h0000))
        else $error("read data outside read cycle");

    // Checks on the link side
    mode_b_a: assert property (
        @(posedge i_bclk) disable iff (!i_arst_n)
        (en_l && lr_rise && pol_l) |=>
        (state_r == L_SHIFT && idx_r == 5'h00))
        else $error("mode B MSB not on first edge");
    mode_a_a: assert property (
        @(posedge i_bclk) disable iff (!i_arst_n)
        (en_l && lr_rise && !pol_l) |=> (state_r == L_WAIT))
        else $error("mode A did not wait one edge");
    frame_end_a: assert property (
        @(posedge i_bclk) disable iff (!i_arst_n)
        (en_l && !lr_rise && state_r == L_SHIFT &&
         (idx_r + 5'h01) == last_idx)
        |=> (rx_tgl_r != $past(rx_tgl_r) && state_r == L_IDLE))
        else $error("frame length wrong");
    tx_msb_a: assert property (
        @(posedge i_bclk) disable iff (!i_arst_n)
        (en_l && first) |=> (o_tx_sdata == $past(tx_buf_r[31])))
        else $error("slot does not start with MSB");
endmodule // acl_core
`default_nettype wire

// [pkg/acl_pkg.sv]
`default_nettype none
package acl_pkg;
    // Control register location and field positions
    localparam logic [7:0] ACL_CTRL_ADDR = 8'h71;
    localparam int ACL_LOOP_BIT = 0;
    localparam int ACL_TX_LAW_BIT = 4;
    localparam int ACL_TX_EN_BIT = 5;
    localparam int ACL_RX_LAW_BIT = 6;
    localparam int ACL_RX_EN_BIT = 7;
    localparam int ACL_POL_BIT = 8;
    localparam int ACL_SHORT_BIT = 9;
    localparam logic [15:0] ACL_CTRL_RESET = 16'h0000;
    localparam logic [15:0] ACL_CTRL_WMASK = 16'h01f1;
    // Last bit index of a two-channel frame, 8-bit and 16-bit words
    localparam logic [4:0] ACL_LAST_SHORT = 5'h0f;
    localparam logic [4:0] ACL_LAST_LONG = 5'h1f;
    // Curve parameters that the segment tables approximate
    localparam int ACL_MU = 255;
    localparam real ACL_A = 87.6;
    // Segment arithmetic constants
    localparam logic [13:0] ACL_MU_BIAS = 14'h0021;
    localparam logic [14:0] ACL_MU_CLIP = 15'h1fde;
    localparam logic [15:0] ACL_MU_XBIAS = 16'h0084;
    localparam logic [7:0] ACL_A_XOR = 8'h55;
    localparam logic [15:0] ACL_A_SEG0 = 16'h0008;
    localparam logic [15:0] ACL_A_SEGN = 16'h0108;
    // Stereo sample pair, left in the upper half
    typedef struct packed {
        logic [15:0] left;
        logic [15:0] right;
    } acl_pair_type;
endpackage
`default_nettype wire

// [core/acl_compress.sv]
`timescale 1ns/10ps
`default_nettype none
module acl_compress (
    // Linear sample in
    input wire logic [15:0] i_sample,
    input wire logic i_alaw,
    // Companded byte out
    output logic [7:0] o_code
);
    import acl_pkg::*;

    logic neg;
    logic [15:0] ones;
    logic [16:0] mu_abs;
    logic [14:0] mu_lin;
    logic [13:0] mu_mag;
    logic [11:0] a_mag;
    logic [2:0] mu_seg;
    logic [2:0] a_seg;
    logic [3:0] mu_man;
    logic [3:0] a_man;

    // Segment search and mantissa pick for both laws
    always_comb begin
        neg = i_sample[15];
        ones = neg ? ~i_sample : i_sample;
        mu_abs = neg ? ({1'b0, ~i_sample} + 17'h00001) : {1'b0, i_sample};
        mu_lin = mu_abs[16:2]; // 13 magnitude bits
        if (mu_lin > ACL_MU_CLIP) begin
            mu_lin = ACL_MU_CLIP; // Keeps biased value inside segment 7
        end
        mu_mag = mu_lin[13:0] + ACL_MU_BIAS;
        mu_seg = 3'h0;
        for (int k = 0; k < 7; k++) begin
            if (mu_mag[k + 6]) begin
                mu_seg = 3'(k + 1);
            end
        end
        mu_man = 4'(mu_mag >> ({1'b0, mu_seg} + 4'h1)); // Segment 7 shifts 8
        a_mag = ones[14:3]; // 12 magnitude bits
        a_seg = 3'h0;
        for (int k = 0; k < 7; k++) begin
            if (a_mag[k + 5]) begin
                a_seg = 3'(k + 1);
            end
        end
        a_man = (a_seg < 3'h2) ? a_mag[4:1] : 4'(a_mag >> a_seg);
        // Sign, exponent, mantissa, then line inversion
        if (i_alaw) begin
            o_code = {~neg, a_seg, a_man} ^ ACL_A_XOR;
        end else begin
            o_code = ~{neg, mu_seg, mu_man};
        end
    end
endmodule // acl_compress
`default_nettype wire

// [core/acl_expand.sv]
`timescale 1ns/10ps
`default_nettype none
module acl_expand (
    // Companded byte in
    input wire logic [7:0] i_code,
    input wire logic i_alaw,
    // Linear sample out
    output logic [15:0] o_sample
);
    import acl_pkg::*;

    logic [7:0] u;
    logic [7:0] a;
    logic [15:0] mu_t;
    logic [15:0] a_t;

    // Undo inversion, rebuild segment value, apply sign
    always_comb begin
        u = ~i_code;
        mu_t = ({8'h00, 1'b0, u[3:0], 3'h0} + ACL_MU_XBIAS) << u[6:4];
        a = i_code ^ ACL_A_XOR;
        a_t = {8'h00, a[3:0], 4'h0};
        if (a[6:4] == 3'h0) begin
            a_t = a_t + ACL_A_SEG0;
        end else begin
            a_t = (a_t + ACL_A_SEGN) << (a[6:4] - 3'h1);
        end
        if (i_alaw) begin
            o_sample = a[7] ? a_t : (16'h0000 - a_t);
        end else begin
            o_sample = u[7] ? (ACL_MU_XBIAS - mu_t) : (mu_t - ACL_MU_XBIAS);
        end
    end
endmodule // acl_expand
`default_nettype wire

// [testbench/acl_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module acl_host_model (
    // Serial link from the block
    input wire logic i_tx_sdata,
    // Serial link to the block
    output logic o_bclk,
    output logic o_lrclk,
    output logic o_rx_sdata
);
    logic run_r = 1'b0;

    // Bit clock, stands low outside transfers
    initial begin
        o_bclk = 1'b0;
        o_lrclk = 1'b0;
        o_rx_sdata = 1'b0;
        #3;
        forever begin
            #6;
            o_bclk = run_r ? ~o_bclk : 1'b0;
        end
    end

    // One frame, lines driven on falling edges, idle cycles around it
    task automatic xfer(input logic [31:0] rx, input int nbits,
                        input logic mode_b, output logic [31:0] tx);
        int off;
        off = mode_b ? 0 : 1; // MSB on first or second edge
        tx = '0;
        run_r = 1'b1;
        repeat (8) @(negedge o_bclk);
        for (int i = 0; i < nbits + off; i++) begin
            o_lrclk = (i == 0); // One-cycle frame pulse
            if (i >= off)
                o_rx_sdata = rx[31 - i + off]; // MSB first, nbits/2 per word
            else
                o_rx_sdata = ~o_rx_sdata;
            @(negedge o_bclk);
            if (i >= off)
                tx[31 - i + off] = i_tx_sdata;
        end
        o_lrclk = 1'b0;
        o_rx_sdata = ~o_rx_sdata; // Released line shows the inverse
        repeat (8) @(negedge o_bclk);
        run_r = 1'b0;
    endtask
endmodule // acl_host_model
`default_nettype wire

// [testbench/audio_companding_loopback_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module audio_companding_loopback_tb;
    import acl_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic adc_valid = 1'b0;
    acl_pair_type adc = '0;
    logic dac_valid;
    acl_pair_type dac;
    logic bclk;
    logic lrclk;
    logic rx_sdata;
    logic tx_sdata;
    int n_errors = 0;
    int check_count = 0;

    // System clock, 50 ns
    always #25 sys_clk = ~sys_clk;

    acl_core dut_u (
        .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_clk_en(clk_en),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
        .i_adc_valid(adc_valid), .i_adc(adc),
        .o_dac_valid(dac_valid), .o_dac(dac),
        .i_bclk(bclk), .i_lrclk(lrclk), .i_rx_sdata(rx_sdata),
        .o_tx_sdata(tx_sdata)
    );

    acl_host_model host_u (
        .i_tx_sdata(tx_sdata), .o_bclk(bclk), .o_lrclk(lrclk),
        .o_rx_sdata(rx_sdata)
    );

    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Compare one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Register write, one strobe cycle
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Register read, data taken in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Read and compare
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        reg_read(a, d);
        chk({16'h0000, d}, {16'h0000, exp});
    endtask

    // ADC pair pulse
    task automatic adc_push(input logic [31:0] v);
        @(posedge sys_clk);
        adc <= v;
        adc_valid <= 1'b1;
        @(posedge sys_clk);
        adc_valid <= 1'b0;
    endtask

    // Bounded wait for the DAC pulse
    task automatic wait_dac(output logic [31:0] got);
        int k;
        for (k = 0; k < 200; k++) begin
            @(posedge sys_clk);
            #1;
            if (dac_valid === 1'b1)
                break;
        end
        got = dac;
        if (k == 200) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
            tally_and_finish();
        end
    endtask

    // Reset values, masks, status bit, unmapped places
    task automatic t_regs();
        rd_chk(ACL_CTRL_ADDR, 16'h0000);
        reg_write(8'h70, 16'hffff);
        rd_chk(ACL_CTRL_ADDR, 16'h0000);
        rd_chk(8'h70, 16'h0000);
        reg_write(ACL_CTRL_ADDR, 16'hffff);
        rd_chk(ACL_CTRL_ADDR, 16'h03f1);
        reg_write(ACL_CTRL_ADDR, 16'h0050);
        rd_chk(ACL_CTRL_ADDR, 16'h0250);
        reg_write(ACL_CTRL_ADDR, 16'h0000);
        rd_chk(ACL_CTRL_ADDR, 16'h0000);
        // A write while the clock enable is low must not land
        @(posedge sys_clk);
        clk_en <= 1'b0;
        reg_write(ACL_CTRL_ADDR, 16'h0001);
        clk_en <= 1'b1;
        rd_chk(ACL_CTRL_ADDR, 16'h0000);
    endtask

    // Loopback on passes the pair, off passes nothing
    task automatic t_loop();
        logic [31:0] got;
        int seen;
        reg_write(ACL_CTRL_ADDR, 16'h0001);
        fork
            adc_push(32'h8000_7fff);
            wait_dac(got);
        join
        chk(got, 32'h8000_7fff);
        reg_write(ACL_CTRL_ADDR, 16'h0000);
        seen = 0;
        adc_push(32'h1111_2222);
        repeat (30) begin
            @(posedge sys_clk);
            #1 seen += (dac_valid === 1'b1);
        end
        chk(seen, 0);
    endtask

    // Transmit frame after one ADC pair
    task automatic t_tx(input logic [15:0] ctrl, input logic [31:0] v,
                        input int nbits, input logic [31:0] exp);
        logic [31:0] tx;
        reg_write(ACL_CTRL_ADDR, ctrl);
        adc_push(v);
        repeat (10) @(posedge sys_clk);
        host_u.xfer(32'h0000_0000, nbits, 1'b1, tx);
        chk(tx, exp);
    endtask

    // Receive frame decoded onto the DAC side
    task automatic t_rx(input logic [15:0] ctrl, input logic [31:0] rx,
                        input int nbits, input logic mode_b,
                        input logic [31:0] exp);
        logic [31:0] tx;
        logic [31:0] got;
        reg_write(ACL_CTRL_ADDR, ctrl);
        repeat (4) @(posedge sys_clk);
        fork
            host_u.xfer(rx, nbits, mode_b, tx);
            wait_dac(got);
        join
        chk(got, exp);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_regs();
        t_loop();
        t_tx(16'h0120, 32'h7fff_0000, 16, 32'h80ff_0000);
        t_tx(16'h0130, 32'h8000_7fff, 16, 32'h2aaa_0000);
        t_tx(16'h0100, 32'h1357_9bdf, 32, 32'h1357_9bdf);
        t_tx(16'h0120, 32'h437c_0000, 16, 32'h8eff_0000);
        t_tx(16'h0110, 32'h1357_9bdf, 16, 32'h139b_0000);
        t_rx(16'h0180, 32'hff80_0000, 16, 1'b1, 32'h0000_7d7c);
        t_rx(16'h01c0, 32'hd52a_0000, 16, 1'b1, 32'h0008_8200);
        t_rx(16'h0140, 32'h1234_0000, 16, 1'b1, 32'h1200_3400);
        t_rx(16'h0040, 32'h569a_0000, 16, 1'b0, 32'h5600_9a00);
        t_rx(16'h0100, 32'h1234_abcd, 32, 1'b1, 32'h1234_abcd);
        tally_and_finish();
    end
endmodule // audio_companding_loopback_tb
`default_nettype wire
